// ===== design/sad_pkg.sv
// Purpose: Shared constants for the sliced ALU status and decode block.
// Assumes: Opcode fields are nibbles of an 8-bit instruction word.
// Notes: Offsets are byte addresses on the register bus.
package sad_pkg;
   // ----------------
   // Register bus map
   // ----------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam logic [7:0] ADDR_MQ = 8'h08;
   localparam logic [2:0] CTRL_RESET = 3'h0;
   localparam int CTRL_OVR_BIT = 0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ----------------
   // Instruction groups and codes
   // ----------------
   typedef enum logic [2:0] {
      GRP_ONE = 3'h1, GRP_THREE = 3'h3, GRP_FOUR = 3'h4, GRP_FIVE = 3'h5
   } sad_group_e;
   localparam logic [3:0] F_G4 = 4'h0;
   localparam logic [3:0] F_ADD = 4'h1;
   localparam logic [3:0] F_SUBR = 4'h2;
   localparam logic [3:0] F_SUBS = 4'h3;
   localparam logic [3:0] F_INCS = 4'h4;
   localparam logic [3:0] F_INCNS = 4'h5;
   localparam logic [3:0] F_INCR = 4'h6;
   localparam logic [3:0] F_INCNR = 4'h7;
   localparam logic [3:0] F_G3 = 4'h8;
   localparam logic [3:0] F_XOR = 4'h9;
   localparam logic [3:0] F_AND = 4'ha;
   localparam logic [3:0] F_OR = 4'hb;
   localparam logic [3:0] F_NAND = 4'hc;
   localparam logic [3:0] F_NOR = 4'hd;
   localparam logic [3:0] F_ANDNR = 4'he;
   localparam logic [3:0] F_G5 = 4'hf;
   localparam logic [3:0] SH_SRA = 4'h0;
   localparam logic [3:0] SH_SRAD = 4'h1;
   localparam logic [3:0] SH_SRL = 4'h2;
   localparam logic [3:0] SH_SRLD = 4'h3;
   localparam logic [3:0] SH_SLA = 4'h4;
   localparam logic [3:0] SH_SLAD = 4'h5;
   localparam logic [3:0] SH_SLC = 4'h6;
   localparam logic [3:0] SH_SLCD = 4'h7;
   localparam logic [3:0] SH_SRC = 4'h8;
   localparam logic [3:0] SH_SRCD = 4'h9;
   localparam logic [3:0] SH_MQSRA = 4'ha;
   localparam logic [3:0] SH_MQSRL = 4'hb;
   localparam logic [3:0] SH_MQSLL = 4'hc;
   localparam logic [3:0] SH_MQSLC = 4'hd;
   localparam logic [3:0] SH_LOAD_MUL_QUOT = 4'he;
   localparam logic [7:0] OP_RESTORE = 8'h0f;
   localparam logic [7:0] OP_EXPORT = 8'h5f;
   localparam logic [7:0] OP_NOP = 8'hff;
   localparam logic [15:0] CLEAR_SET = 16'h585e;
   // ----------------
   // Width modes and test pin codes
   // ----------------
   localparam logic [2:0] W_LSW = 3'h4;
   localparam logic [2:0] W_MSW = 3'h5;
   localparam logic [2:0] W_MASK = 3'h7;
   localparam logic [1:0] TEST_LOW = 2'h0;
   localparam logic [1:0] TEST_HIGH = 2'h1;
   localparam logic [1:0] TEST_HIZ = 2'h2;
   localparam logic [1:0] TEST_NORMAL = 2'h3;
   localparam logic [9:0] FLAG_RESET = 10'h000;
endpackage

// ===== design/sad_alu_core.sv
// Purpose: Registered sliced ALU with shifter, flags, checks, decode.
// Assumes: Controller logic shares core_clk; test pins are asynchronous.
// Notes:
// Notes on behaviour
// - Shift enable high passes the shifted ALU result to the Y outputs.
// - Shift enable low passes unshifted result and holds the MQ register.
// - With Y enable high, compare internal Y bytes against external Y bytes.
// - The same comparison covers the Y check bits.
// - Multiply/divide flip-flops carry status between instructions.
// - Excess-3 work stores each nibble carry in decimal carry flip-flops.
// - All but no-operation update decimal carries; clear zeroes them.
// - One opcode restores the flag state, another exports it on Y.
// - Eight status outputs; sign, zero, carry, overflow follow width select.
// - Carry is taken before shifting; sign and zero after shifting.
// - Overflow is ALU overflow ORed with shifter overflow.
// - Lane overflow flags map to word, half words or bytes by width.
// - Each input byte with its check bit is counted for even parity.
// - Check bit 0 goes with the least significant byte of its port.
// - Any odd byte raises the error output of that port.
// - Test select forces outputs low, high, released, or normal.
// - An 8-bit opcode arrives each cycle and decodes to four groups.
// - Low nibble 1 to 7 are arithmetic; 0, 8, F pick groups 4, 3, 5.
// - Low nibble 9 to E are the six bitwise logic functions.
// - Upper nibble selects the shift, MQ load, or unshifted pass.
// - Low nibble 8 opcodes are the bit and byte operations.
// - Low nibble 0 opcodes are the multiply, divide and normalize steps.
// - Width select picks lane layout and the lane that feeds status.
// - The MQ register takes the MQ shifter output each rising edge with clk_en high.
// - Logic operations ignore carry-in and force carry-out to zero.
`timescale 1ns/10ps
module sad_alu_core #(
   parameter int ADDR_W = 8
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic [7:0] opcode_in,
   input wire logic [2:0] width_select,
   input wire logic carry_in,
   input wire logic conditional_shift_enable,
   input wire logic y_output_enable_n,
   input wire logic [1:0] test_select,
   input wire logic [31:0] operand_port_a,
   input wire logic [3:0] check_bits_a,
   input wire logic [31:0] operand_port_b,
   input wire logic [3:0] check_bits_b,
   input wire logic [31:0] y_in,
   input wire logic [3:0] check_bits_y_in,
   output logic [31:0] y_out,
   output logic [3:0] check_bits_y_out,
   output logic y_oe,
   output logic sign_flag,
   output logic zero_flag,
   output logic carry_out,
   output logic overflow_flag,
   output logic [3:0] lane_overflow,
   output logic lockstep_mismatch,
   output logic check_error_a,
   output logic check_error_b,
   output logic check_error_y,
   output logic pins_oe,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // ----------------
   // Opcode decode
   // ----------------
   logic [3:0] lo_nib, hi_nib, fsel;
   logic is_g1, is_clear, is_muldiv, force8, is_logic;
   sad_pkg::sad_group_e grp;

   assign lo_nib = opcode_in[3:0];
   assign hi_nib = opcode_in[7:4];
   assign is_g1 = grp == sad_pkg::GRP_ONE;
   assign is_clear = grp == sad_pkg::GRP_FIVE &&
      sad_pkg::CLEAR_SET[hi_nib];
   assign is_muldiv = grp == sad_pkg::GRP_FOUR && hi_nib >= 4'h6;

   always_comb begin
      if (lo_nib == sad_pkg::F_G4) begin
         grp = sad_pkg::GRP_FOUR;
      end else if (lo_nib == sad_pkg::F_G3) begin
         grp = sad_pkg::GRP_THREE;
      end else if (lo_nib == sad_pkg::F_G5) begin
         grp = sad_pkg::GRP_FIVE;
      end else begin
         grp = sad_pkg::GRP_ONE;
      end
   end

   // Byte group ops reuse the group 1 function units on forced byte
   // lanes; bit, immediate and conversion codes decode to a pass of S.
   always_comb begin
      fsel = lo_nib;
      force8 = 1'b0;
      case (grp)
         sad_pkg::GRP_THREE: begin
            force8 = hi_nib[3];
            case (hi_nib)
               4'h8: fsel = sad_pkg::F_ADD;
               4'h9: fsel = sad_pkg::F_SUBS;
               4'ha: fsel = sad_pkg::F_SUBR;
               4'hb: fsel = sad_pkg::F_INCS;
               4'hc: fsel = sad_pkg::F_INCNS;
               4'hd: fsel = sad_pkg::F_XOR;
               4'he: fsel = sad_pkg::F_AND;
               4'hf: fsel = sad_pkg::F_OR;
               default: fsel = sad_pkg::F_INCS;
            endcase
         end
         sad_pkg::GRP_FOUR: begin
            fsel = (hi_nib >= 4'h6) ? sad_pkg::F_ADD : sad_pkg::F_INCS;
         end
         sad_pkg::GRP_FIVE: fsel = sad_pkg::F_INCS;
         default: fsel = lo_nib;
      endcase
   end

   assign is_logic = fsel >= sad_pkg::F_XOR;

   // ----------------
   // Operand forming and sliced adder
   // ----------------
   logic [31:0] r_bus, a_op, b_op, sum, logic_res, alu_res;
   logic [3:0] lane_start, byte_cout, byte_ovf, chain;
   logic [7:0] nib_carry;

   assign r_bus = (width_select == sad_pkg::W_MASK) ?
      {20'h00000, operand_port_a[11:0]} : operand_port_a;

   always_comb begin
      a_op = r_bus;
      b_op = operand_port_b;
      case (fsel)
         sad_pkg::F_SUBR: a_op = ~r_bus;
         sad_pkg::F_SUBS: b_op = ~operand_port_b;
         sad_pkg::F_INCS: a_op = 32'h00000000;
         sad_pkg::F_INCNS: begin
            a_op = 32'h00000000;
            b_op = ~operand_port_b;
         end
         sad_pkg::F_INCR: b_op = 32'h00000000;
         sad_pkg::F_INCNR: begin
            a_op = ~r_bus;
            b_op = 32'h00000000;
         end
         default: a_op = r_bus;
      endcase
   end

   always_comb begin
      if (force8 || !width_select[2]) begin
         lane_start = 4'hf;
      end else if (width_select == sad_pkg::W_LSW ||
                   width_select == sad_pkg::W_MSW) begin
         lane_start = 4'h5;
      end else begin
         lane_start = 4'h1;
      end
   end

   assign chain = {byte_cout[2:0], carry_in};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_byte
         logic cin;
         logic [4:0] lo_s;
         logic [4:0] hi_s;
         logic [7:0] a8;
         logic [7:0] b8;
         assign a8 = a_op[8*gi +: 8];
         assign b8 = b_op[8*gi +: 8];
         assign cin = lane_start[gi] ? carry_in : chain[gi];
         assign lo_s = {1'b0, a8[3:0]} + {1'b0, b8[3:0]} + {4'h0, cin};
         assign hi_s = {1'b0, a8[7:4]} + {1'b0, b8[7:4]} +
            {4'h0, lo_s[4]};
         assign sum[8*gi +: 8] = {hi_s[3:0], lo_s[3:0]};
         assign nib_carry[2*gi +: 2] = {hi_s[4], lo_s[4]};
         assign byte_cout[gi] = hi_s[4];
         assign byte_ovf[gi] = (a8[7] == b8[7]) && (hi_s[3] != a8[7]);
      end
   endgenerate

   always_comb begin
      case (fsel)
         sad_pkg::F_XOR: logic_res = r_bus ^ operand_port_b;
         sad_pkg::F_AND: logic_res = r_bus & operand_port_b;
         sad_pkg::F_OR: logic_res = r_bus | operand_port_b;
         sad_pkg::F_NAND: logic_res = ~(r_bus & operand_port_b);
         sad_pkg::F_NOR: logic_res = ~(r_bus | operand_port_b);
         default: logic_res = ~r_bus & operand_port_b;
      endcase
   end

   assign alu_res = is_logic ? logic_res : sum;

   // ----------------
   // ALU and MQ shifters
   // ----------------
   logic [31:0] mq, shifted, next_mq;
   logic sh_ovf;

   // Shifts act on the whole word; lane-local end fill is not modelled.
   always_comb begin
      shifted = alu_res;
      next_mq = mq;
      sh_ovf = 1'b0;
      if (is_g1 && conditional_shift_enable) begin
         case (hi_nib)
            sad_pkg::SH_SRA: shifted = {alu_res[31], alu_res[31:1]};
            sad_pkg::SH_SRAD: begin
               shifted = {alu_res[31], alu_res[31:1]};
               next_mq = {alu_res[0], mq[31:1]};
            end
            sad_pkg::SH_SRL: shifted = {1'b0, alu_res[31:1]};
            sad_pkg::SH_SRLD: begin
               shifted = {1'b0, alu_res[31:1]};
               next_mq = {alu_res[0], mq[31:1]};
            end
            sad_pkg::SH_SLA: begin
               shifted = {alu_res[30:0], 1'b0};
               sh_ovf = alu_res[31] ^ alu_res[30];
            end
            sad_pkg::SH_SLAD: begin
               shifted = {alu_res[30:0], mq[31]};
               next_mq = {mq[30:0], 1'b0};
               sh_ovf = alu_res[31] ^ alu_res[30];
            end
            sad_pkg::SH_SLC: shifted = {alu_res[30:0], alu_res[31]};
            sad_pkg::SH_SLCD: begin
               shifted = {alu_res[30:0], mq[31]};
               next_mq = {mq[30:0], alu_res[31]};
            end
            sad_pkg::SH_SRC: shifted = {alu_res[0], alu_res[31:1]};
            sad_pkg::SH_SRCD: begin
               shifted = {mq[0], alu_res[31:1]};
               next_mq = {alu_res[0], mq[31:1]};
            end
            sad_pkg::SH_MQSRA: next_mq = {mq[31], mq[31:1]};
            sad_pkg::SH_MQSRL: next_mq = {1'b0, mq[31:1]};
            sad_pkg::SH_MQSLL: next_mq = {mq[30:0], 1'b0};
            sad_pkg::SH_MQSLC: next_mq = {mq[30:0], mq[31]};
            sad_pkg::SH_LOAD_MUL_QUOT: next_mq = alu_res;
            default: shifted = alu_res;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         mq <= 32'h00000000;
      end else if (clk_en) begin
         mq <= next_mq;
      end
   end

   // ----------------
   // Divide and decimal carry flip-flops
   // ----------------
   logic [7:0] dec_carry;
   logic [1:0] md_state;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         dec_carry <= sad_pkg::FLAG_RESET[7:0];
         md_state <= sad_pkg::FLAG_RESET[9:8];
      end else if (clk_en && opcode_in != sad_pkg::OP_NOP) begin
         if (is_clear) begin
            dec_carry <= 8'h00;
            md_state <= 2'h0;
         end else if (opcode_in == sad_pkg::OP_RESTORE) begin
            dec_carry <= operand_port_a[7:0];
            md_state <= operand_port_a[9:8];
         end else begin
            dec_carry <= nib_carry;
            if (is_muldiv) begin
               md_state <= {shifted[31], byte_cout[3]};
            end
         end
      end
   end

   // ----------------
   // Status selection
   // ----------------
   logic [1:0] sel_lane;
   logic [31:0] zmask;
   logic [3:0] lane_ovf_n, cvec, vvec;

   assign cvec = is_logic ? 4'h0 : byte_cout;
   assign vvec = is_logic ? 4'h0 : byte_ovf;

   always_comb begin
      if (!width_select[2]) begin
         sel_lane = width_select[1:0];
         zmask = 32'h000000ff << {width_select[1:0], 3'h0};
         lane_ovf_n = vvec;
      end else if (width_select == sad_pkg::W_LSW) begin
         sel_lane = 2'h1;
         zmask = 32'h0000ffff;
         lane_ovf_n = {vvec[3], 1'b0, vvec[1], 1'b0};
      end else if (width_select == sad_pkg::W_MSW) begin
         sel_lane = 2'h3;
         zmask = 32'hffff0000;
         lane_ovf_n = {vvec[3], 1'b0, vvec[1], 1'b0};
      end else begin
         sel_lane = 2'h3;
         zmask = 32'hffffffff;
         lane_ovf_n = {vvec[3], 3'h0};
      end
   end

   // ----------------
   // Output registers, parity checks and lockstep comparator
   // ----------------
   logic [31:0] y_reg, next_y;
   logic [3:0] py_reg, next_py, odd_a, odd_b, odd_y, byte_ne, lane_r;
   logic sgn_r, zero_r, cout_r, ovf_r, mis_r, err_a_r, err_b_r, err_y_r;

   assign next_y = (opcode_in == sad_pkg::OP_EXPORT) ?
      {22'h000000, md_state, dec_carry} : shifted;

   generate
      for (gi = 0; gi < 4; gi++) begin : g_chk
         assign next_py[gi] = ^next_y[8*gi +: 8];
         assign odd_a[gi] = ^{operand_port_a[8*gi +: 8],
            check_bits_a[gi]};
         assign odd_b[gi] = ^{operand_port_b[8*gi +: 8],
            check_bits_b[gi]};
         assign odd_y[gi] = ^{y_in[8*gi +: 8], check_bits_y_in[gi]};
         assign byte_ne[gi] = y_reg[8*gi +: 8] != y_in[8*gi +: 8] ||
            py_reg[gi] != check_bits_y_in[gi];
      end
   endgenerate

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         y_reg <= 32'h00000000;
         py_reg <= 4'h0;
      end else if (clk_en) begin
         y_reg <= next_y;
         py_reg <= next_py;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         sgn_r <= 1'b0;
         zero_r <= 1'b0;
         cout_r <= 1'b0;
         ovf_r <= 1'b0;
         lane_r <= 4'h0;
         mis_r <= 1'b0;
         err_a_r <= 1'b0;
         err_b_r <= 1'b0;
         err_y_r <= 1'b0;
      end else if (clk_en) begin
         sgn_r <= shifted[{sel_lane, 3'h7}];
         zero_r <= (shifted & zmask) == 32'h00000000;
         cout_r <= cvec[sel_lane];
         ovf_r <= vvec[sel_lane] | sh_ovf;
         lane_r <= lane_ovf_n;
         mis_r <= y_output_enable_n && (|byte_ne);
         err_a_r <= |odd_a;
         err_b_r <= |odd_b;
         err_y_r <= |odd_y;
      end
   end

   // ----------------
   // Test pin forcing
   // ----------------
   logic [1:0] test_meta, test_sync, test_eff;
   logic [2:0] ctrl;
   logic [47:0] pin_norm, pin_out;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         test_meta <= sad_pkg::TEST_NORMAL;
         test_sync <= sad_pkg::TEST_NORMAL;
      end else begin
         test_meta <= test_select;
         test_sync <= test_meta;
      end
   end

   // Software may override the pins so a board can be isolated remotely.
   assign test_eff = ctrl[sad_pkg::CTRL_OVR_BIT] ? ctrl[2:1] : test_sync;
   assign pin_norm = {y_reg, py_reg, sgn_r, zero_r, cout_r, ovf_r,
      lane_r, mis_r, err_a_r, err_b_r, err_y_r};

   always_comb begin
      case (test_eff)
         sad_pkg::TEST_LOW: pin_out = '0;
         sad_pkg::TEST_HIGH: pin_out = '1;
         default: pin_out = pin_norm;
      endcase
   end

   assign {y_out, check_bits_y_out, sign_flag, zero_flag, carry_out,
      overflow_flag, lane_overflow, lockstep_mismatch, check_error_a,
      check_error_b, check_error_y} = pin_out;
   assign pins_oe = test_eff != sad_pkg::TEST_HIZ;
   assign y_oe = test_eff == sad_pkg::TEST_NORMAL ? !y_output_enable_n :
      test_eff != sad_pkg::TEST_HIZ;

   // ----------------
   // AXI4-Lite slave
   // ----------------
   logic wr_take, rd_take, rd_hit;
   logic [31:0] rd_word;

   assign wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_awready = wr_take;
   assign s_axi_wready = wr_take;
   assign rd_take = s_axi_arvalid && !s_axi_rvalid;
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ctrl <= sad_pkg::CTRL_RESET;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= sad_pkg::RESP_OKAY;
      end else if (wr_take) begin
         s_axi_bvalid <= 1'b1;
         if (s_axi_awaddr[7:0] == sad_pkg::ADDR_CTRL) begin
            s_axi_bresp <= sad_pkg::RESP_OKAY;
            if (s_axi_wstrb[0]) begin
               ctrl <= s_axi_wdata[2:0];
            end
         end else if (s_axi_awaddr[7:0] == sad_pkg::ADDR_STAT ||
                      s_axi_awaddr[7:0] == sad_pkg::ADDR_MQ) begin
            s_axi_bresp <= sad_pkg::RESP_OKAY;
         end else begin
            s_axi_bresp <= sad_pkg::RESP_SLVERR;
         end
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_comb begin
      rd_hit = 1'b1;
      if (s_axi_araddr[7:0] == sad_pkg::ADDR_CTRL) begin
         rd_word = {29'h00000000, ctrl};
      end else if (s_axi_araddr[7:0] == sad_pkg::ADDR_STAT) begin
         rd_word = {10'h000, md_state, dec_carry, mis_r, err_a_r,
            err_b_r, err_y_r, sgn_r, zero_r, cout_r, ovf_r, lane_r};
      end else if (s_axi_araddr[7:0] == sad_pkg::ADDR_MQ) begin
         rd_word = mq;
      end else begin
         rd_word = 32'h00000000;
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= sad_pkg::RESP_OKAY;
      end else if (rd_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_hit ? sad_pkg::RESP_OKAY : sad_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// ===== verif/sad_alu_sva.sv
// Purpose: Port-level checks of the sliced ALU datapath.
// Assumes: A test override in the control register forces no level.
// Notes: Datapath checks wait for four normal test-pin samples.
`timescale 1ns/10ps
module sad_alu_sva (
   input wire logic core_clk, reset, clk_en, carry_in, y_output_enable_n,
   input wire logic conditional_shift_enable, y_oe, pins_oe, sign_flag,
   input wire logic zero_flag, carry_out, lockstep_mismatch, check_error_a,
   input wire logic check_error_b, check_error_y, overflow_flag,
   input wire logic [1:0] test_select,
   input wire logic [2:0] width_select,
   input wire logic [7:0] opcode_in,
   input wire logic [3:0] check_bits_a, check_bits_b, check_bits_y_in,
   input wire logic [3:0] check_bits_y_out, lane_overflow,
   input wire logic [31:0] operand_port_a, operand_port_b, y_in, y_out
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   function automatic logic odd(logic [31:0] d, logic [3:0] p);
      return |({^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]} ^ p);
   endfunction
   logic [31:0] sum;
   logic ovf;
   assign sum = operand_port_a + operand_port_b + carry_in;
   assign ovf = operand_port_a[31] == operand_port_b[31] &&
      sum[31] != operand_port_a[31];
   // The test pins pass a two-stage synchroniser, so allow it to settle.
   sequence s_norm;
      (test_select == 2'h3) [*4] ##0 clk_en;
   endsequence
   sequence s_tpin;
      (!test_select[1] && $stable(test_select)) [*4];
   endsequence
   property p_arith;
      s_norm ##0 opcode_in[3:0] == 4'h1 && width_select == 3'h6 &&
      (opcode_in[7:4] == 4'hf || !conditional_shift_enable)
      |=> y_out == $past(sum);
   endproperty
   property p_shift;
      s_norm ##0 opcode_in == 8'h21 && width_select == 3'h6 &&
      conditional_shift_enable |=> y_out == $past(sum) >> 1;
   endproperty
   property p_logic;
      s_norm ##0 opcode_in[3:0] inside {[4'h9:4'he]} |=> !carry_out;
   endproperty
   property p_flags;
      s_norm ##0 width_select == 3'h6 &&
      opcode_in[3:0] inside {[4'h1:4'h7], [4'h9:4'he]}
      |=> zero_flag == (y_out == 32'h0) && sign_flag == y_out[31];
   endproperty
   property p_perr;
      s_norm |=> {check_error_a, check_error_b, check_error_y} ==
      $past({odd(operand_port_a, check_bits_a),
      odd(operand_port_b, check_bits_b), odd(y_in, check_bits_y_in)});
   endproperty
   property p_mism;
      s_norm |=> lockstep_mismatch == $past(y_output_enable_n &&
      (y_out != y_in || check_bits_y_out != check_bits_y_in));
   endproperty
   property p_tfix;
      s_tpin |-> y_out == {32{test_select[0]}} &&
      carry_out == test_select[0] && y_oe;
   endproperty
   property p_ovf;
      s_norm ##0 opcode_in == 8'hf1 && width_select == 3'h6
      |=> overflow_flag == $past(ovf) && lane_overflow == {$past(ovf), 3'h0};
   endproperty
   property p_thiz;
      (test_select == 2'h2) [*4] |-> !y_oe && !pins_oe;
   endproperty
   a_arith: assert property (p_arith) else $error("sum wrong");
   a_shift: assert property (p_shift) else $error("shift wrong");
   a_logic: assert property (p_logic) else $error("carry set");
   a_flags: assert property (p_flags) else $error("flags wrong");
   a_perr: assert property (p_perr) else $error("check err");
   a_mism: assert property (p_mism) else $error("mismatch");
   a_tfix: assert property (p_tfix) else $error("forced level");
   a_thiz: assert property (p_thiz) else $error("not released");
   a_ovf: assert property (p_ovf) else $error("overflow wrong");
endmodule
bind sad_alu_core sad_alu_sva u_sva (.*);

// ===== verif/sad_ctl_model.sv
// Purpose: Random microprogram controller feeding the datapath.
// Assumes: A new instruction and operand set every cycle.
// Notes: Input bad spoils one check bit on operand A and on Y.
`timescale 1ns/10ps
module sad_ctl_model (
   input wire logic core_clk, bad,
   output logic clk_en, carry_in, conditional_shift_enable, y_output_enable_n,
   output logic [2:0] width_select,
   output logic [7:0] opcode_in,
   output logic [3:0] check_bits_a, check_bits_b, check_bits_y_in,
   output logic [31:0] operand_port_a, operand_port_b, y_in
);
   int seed = 78;
   logic [31:0] a, b, y;
   function automatic logic [3:0] par(logic [31:0] d);
      return {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
   endfunction
   task automatic draw;
      a = $random(seed);
      b = $random(seed);
      y = $random(seed);
      opcode_in <= 8'($random(seed));
      clk_en <= ($random(seed) & 7) != 0;
      // Favour the full word so that whole-word sums are seen often.
      width_select <= ($random(seed) & 1) ? 3'h6 : 3'($random(seed));
      {carry_in, conditional_shift_enable, y_output_enable_n} <=
         3'($random(seed));
      operand_port_a <= a;
      check_bits_a <= par(a) ^ {3'h0, bad};
      operand_port_b <= b;
      check_bits_b <= par(b);
      y_in <= y;
      check_bits_y_in <= par(y) ^ {bad, 3'h0};
   endtask
   initial draw;
   always @(posedge core_clk) draw;
endmodule

// ===== verif/tb_top.sv
// Purpose: Self-checking bench for the sliced ALU block.
// Assumes: Bus answers are compared in the order they were asked.
// Notes: Test pins are stepped through all codes mid-run.
`timescale 1ns/10ps
module tb_top;
   logic core_clk = 0, reset = 1, bad = 0, ok = 0, dv = 0;
   logic [1:0] test_select = 2'h3, s_axi_bresp, s_axi_rresp;
   logic clk_en, carry_in, conditional_shift_enable, y_output_enable_n;
   logic [2:0] width_select;
   logic [7:0] opcode_in, s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [3:0] check_bits_a, check_bits_b, check_bits_y_in, check_bits_y_out;
   logic [3:0] lane_overflow, s_axi_wstrb = 4'hf;
   logic [31:0] operand_port_a, operand_port_b, y_in, y_out, s_axi_rdata;
   logic [31:0] s_axi_wdata = 0;
   logic y_oe, sign_flag, zero_flag, carry_out, overflow_flag, pins_oe;
   logic lockstep_mismatch, check_error_a, check_error_b, check_error_y;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_rvalid, s_axi_bvalid;
   logic s_axi_awready, s_axi_wready, s_axi_arready;
   logic [33:0] qa[$], qd[$];
   int n_errors = 0, checked = 0;
   sad_ctl_model u_ctl (.*);
   sad_alu_core DUT (.*);
   always #5 core_clk = ~core_clk;
   task chk(input logic [33:0] got, input logic [33:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task end_of_test;
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge core_clk);
      qa.push_back({r, 32'h0});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do @(posedge core_clk); while (!s_axi_awready);
      s_axi_awvalid <= 0;
      s_axi_wvalid <= 0;
      do @(posedge core_clk); while (!s_axi_bvalid);
      s_axi_bready <= 0;
   endtask
   task rd(input logic [7:0] a, input logic [33:0] e);
      @(posedge core_clk);
      qa.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do @(posedge core_clk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      do @(posedge core_clk); while (!s_axi_rvalid);
      s_axi_rready <= 0;
   endtask
   always @(posedge core_clk) begin
      if (s_axi_bvalid && s_axi_bready)
         chk({s_axi_bresp, 32'h0}, qa.pop_front());
      if (s_axi_rvalid && s_axi_rready)
         chk({s_axi_rresp, s_axi_rdata}, qa.pop_front());
      if (dv) chk({2'h0, y_out}, qd.pop_front());
      dv = !reset && ok && clk_en && width_select == 3'h6 &&
         opcode_in == 8'hf1;
      if (dv) qd.push_back({2'h0, operand_port_a + operand_port_b + carry_in});
   end
   initial begin
      repeat (16) @(posedge core_clk);
      reset <= 0;
      ok <= 1;
      wr(8'h00, 32'h5, 2'h0);
      chk({32'h0, pins_oe, y_oe}, 34'h0);
      rd(8'h00, {2'h0, 32'h5});
      wr(8'h00, 32'h0, 2'h0);
      wr(8'h40, 32'h1, 2'h2);
      rd(8'h40, {2'h2, 32'h0});
      wr(8'h04, 32'h1, 2'h0);
      repeat (3000) @(posedge core_clk);
      for (int t = 0; t < 3; t++) begin
         ok <= 0;
         test_select <= 2'(t);
         repeat (6) @(posedge core_clk);
         chk({32'h0, pins_oe, y_oe}, {32'h0, {2{t != 2}}});
      end
      test_select <= 2'h3;
      bad <= 1;
      repeat (40) @(posedge core_clk);
      ok <= 1;
      bad <= 0;
      repeat (3000) @(posedge core_clk);
      end_of_test;
   end
   initial begin
      #150000;
      n_errors++;
      end_of_test;
   end
endmodule
